// ===== verilog/pbd_bus_master.sv
// pbd_bus_master: bus-master dma between host memory and tx/rx fifos
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: config bit 0 picks little (0, reset) or big endian fifo data.
// RULE2: byte swap touches only fifo data; registers map bit n to bit n.
// RULE3: interrupt drives an open-drain pin, low when active.
// RULE4: status bits hold pending events; a status read returns then clears all.
// RULE5: mask register keeps chosen sources off the interrupt pin.
// RULE6: pin stays active while an unmasked bit is pending.
// RULE7: on frame start load hold timer from latency value, count down per clock.
// RULE8: hold timer is an 8-bit down counter.
// RULE9: after grant loss keep bus until timer zero or transfer done.
// RULE10: tx fetches host data into a 2 KB fifo feeding the tx mac.
// RULE11: tx fifo holds at most four whole packets.
// RULE12: tx requests bus only when free space reaches fill threshold.
// RULE13: tx burst keeps filling up to the max burst setting.
// RULE14: rx mac data goes into a 2 KB fifo, then to host memory.
// RULE15: rx status fifo tracks up to four packets.
// RULE16: rx requests bus after drain threshold words arrived.
// RULE17: rx burst ends on empty fifo, packet end or max burst.
// RULE18: bursts are at most 128 long words.
// RULE19: a packet is one descriptor or a chain of fragments.
// RULE20: descriptors hold address and length apart from data, same for both ways; here rx has an address register only, no length.
module pbd_bus_master #(
  parameter int AW = pbd_pkg::FIFO_AW
) (
  // clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  // register port
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWData,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [31:0]        regRData,
  // bus master side
  input  wire logic               busGntN,
  output logic                    busReqN,
  output logic                    busFrameN,
  output logic                    busWrite,
  output logic      [31:0]        busAddr,
  input  wire logic [31:0]        busRData,
  input  wire logic               busRValid,
  output logic      [31:0]        busWData,
  output logic                    busWValid,
  input  wire logic               busWAccept,
  // interrupt pin, open drain
  output logic                    intaOut,
  output logic                    intaOe,
  // transmit mac
  output pbd_pkg::pbd_beat_s      txBeat,
  output logic                    txValid,
  input  wire logic               txReady,
  // receive mac
  input  wire pbd_pkg::pbd_beat_s rxBeat,
  input  wire logic               rxValid,
  input  wire logic [31:0]        rxStatus
);
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  logic [31:0]           regRData_q;
  logic                  bigEnd_q;
  logic [pbd_pkg::IRQ_W-1:0] isr_q, imr_q, isrD, irqEv;
  logic [31:0]           transmit_config_reg_q, receive_config_reg_q, rxStat_q;
  logic [7:0]            lat_q, latTimer_q, beats_q;
  logic                  gntS1_q, gntS2_q, gnt;
  logic                  busReqN_q, busFrameN_q, busWrite_q, reqRx_q;
  logic [31:0]           busAddr_q, busWData_q;
  logic                  busWValid_q, busWEop_q;
  pbd_pkg::pbd_bus_e     busState_q;
  logic                  intaOe_q;
  logic [31:0]           txAddr_q, rxAddr_q;
  logic [pbd_pkg::LEN_W-1:0] txRemain_q;
  logic                  txLastFrag_q;
  logic [AW-1:0]         txWrPtr_q, txRdPtr_q, rxWrPtr_q, rxRdPtr_q;
  logic [AW:0]           txCount_q, rxCount_q, txFree;
  logic [2:0]            txPkts_q, statCnt_q;
  logic [1:0]            statWr_q, statRd_q;
  logic [31:0]           statMem_q [pbd_pkg::MAX_PKTS];
  logic                  txRdPend_q, rxRdPend_q, txValid_q, txStream_q;
  pbd_pkg::pbd_beat_s    txBeat_q, txMemQ, rxMemQ;
  logic                  txWe, txRe, rxAcc, rxRe, rxAccept, busEnd, txWant, rxWant, txBeatEnd;
  logic                  isrRd, preempt;

  assign regRData  = regRData_q;
  assign busReqN   = busReqN_q;
  assign busFrameN = busFrameN_q;
  assign busWrite  = busWrite_q;
  assign busAddr   = busAddr_q;
  assign busWData  = busWData_q;
  assign busWValid = busWValid_q;
  assign intaOe    = intaOe_q;
  assign txBeat    = txBeat_q;
  assign txValid   = txValid_q;

  // grant arrives from a pin: two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gntS1_q <= 1'b1;
      gntS2_q <= 1'b1;
    end else if (ce) begin
      gntS1_q <= busGntN;
      gntS2_q <= gntS1_q;
    end
  end
  assign gnt = !gntS2_q;

  // datapath strobes
  assign txFree  = DEPTH - txCount_q;
  assign txWe    = (busState_q == pbd_pkg::BUS_TXRD) && busRValid;
  assign txRe    = !txValid_q && !txRdPend_q && txCount_q != '0 &&
                   (txStream_q || txPkts_q != '0 ||
                    txCount_q >= transmit_config_reg_q[pbd_pkg::DRAIN_LSB +: pbd_pkg::THR_W]);
  assign rxAcc   = rxValid && rxCount_q != DEPTH &&
                   (!rxBeat.eop || statCnt_q != pbd_pkg::PKT_LIMIT); // [RULE15]
  // no fetch as a cut burst ends: a word staged then would be accepted off the bus
  assign rxRe    = (busState_q == pbd_pkg::BUS_RXWR) && !busWValid_q && !rxRdPend_q &&
                   rxCount_q != '0 && !preempt;
  assign rxAccept = busWValid_q && busWAccept;
  assign preempt = !gnt && latTimer_q == 8'h00; // [RULE9]
  // four whole packets in the fifo block further fetches
  assign txWant  = txRemain_q != '0 && txPkts_q != pbd_pkg::PKT_LIMIT && // [RULE11]
                   txFree >= transmit_config_reg_q[pbd_pkg::FILL_LSB +: pbd_pkg::THR_W]; // [RULE12]
  assign rxWant  = rxCount_q != '0 &&
                   (rxCount_q >= receive_config_reg_q[pbd_pkg::DRAIN_LSB +: pbd_pkg::THR_W] ||
                    statCnt_q != '0); // [RULE16]
  assign txBeatEnd = txRemain_q == 16'h0001 || beats_q == 8'h01 || txFree <= 2; // [RULE13]
  always_comb begin
    busEnd = 1'b0;
    unique case (busState_q)
      pbd_pkg::BUS_IDLE: busEnd = 1'b0;
      pbd_pkg::BUS_TXRD: busEnd = (txWe && txBeatEnd) || (!txWe && preempt);
      pbd_pkg::BUS_RXWR: busEnd = (rxAccept && (busWEop_q || beats_q == 8'h01 ||
                                   rxCount_q == '0)) ||
                                  (!busWValid_q && !rxRdPend_q &&
                                   (rxCount_q == '0 || preempt)); // [RULE17]
    endcase
  end

  // fifo storage, tx from bus to mac and rx from mac to bus
  pbd_fifo_mem #(.AW(AW), .W($bits(pbd_pkg::pbd_beat_s))) uTxMem (
    .clk(clk), .ce(ce), .we(txWe), .wAddr(txWrPtr_q),
    .wData({txRemain_q == 16'h0001 && txLastFrag_q,
            pbd_pkg::endian(busRData, bigEnd_q)}), // [RULE10] [RULE1]
    .re(txRe), .rAddr(txRdPtr_q), .rData(txMemQ)
  );
  pbd_fifo_mem #(.AW(AW), .W($bits(pbd_pkg::pbd_beat_s))) uRxMem (
    .clk(clk), .ce(ce), .we(rxAcc), .wAddr(rxWrPtr_q), .wData(rxBeat), // [RULE14]
    .re(rxRe), .rAddr(rxRdPtr_q), .rData(rxMemQ)
  );

  // tx fifo pointers, packet count and mac output stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txWrPtr_q  <= '0;
      txRdPtr_q  <= '0;
      txCount_q  <= '0;
      txPkts_q   <= '0;
      txRdPend_q <= 1'b0;
      txValid_q  <= 1'b0;
      txStream_q <= 1'b0;
      txBeat_q   <= '0;
    end else if (ce) begin
      if (txWe) txWrPtr_q <= txWrPtr_q + 1'b1;
      if (txRe) txRdPtr_q <= txRdPtr_q + 1'b1;
      txCount_q  <= txCount_q + (AW+1)'(txWe) - (AW+1)'(txRe);
      txPkts_q   <= txPkts_q + 3'(txWe && txRemain_q == 16'h0001 && txLastFrag_q)
                    - 3'(txValid_q && txReady && txBeat_q.eop); // [RULE11]
      txRdPend_q <= txRe;
      if (txRdPend_q) begin
        txBeat_q  <= txMemQ;
        txValid_q <= 1'b1;
        txStream_q <= !txMemQ.eop;
      end else if (txValid_q && txReady) begin
        txValid_q <= 1'b0;
      end
    end
  end

  // rx fifo pointers and per-packet status fifo
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxWrPtr_q <= '0;
      rxRdPtr_q <= '0;
      rxCount_q <= '0;
      statCnt_q <= '0;
      statWr_q  <= '0;
      statRd_q  <= '0;
      rxStat_q  <= '0;
      for (int i = 0; i < pbd_pkg::MAX_PKTS; i++) statMem_q[i] <= '0;
    end else if (ce) begin
      if (rxAcc) rxWrPtr_q <= rxWrPtr_q + 1'b1;
      if (rxRe) rxRdPtr_q <= rxRdPtr_q + 1'b1;
      rxCount_q <= rxCount_q + (AW+1)'(rxAcc) - (AW+1)'(rxRe);
      if (rxAcc && rxBeat.eop) begin
        statMem_q[statWr_q] <= rxStatus; // [RULE15]
        statWr_q <= statWr_q + 1'b1;
      end
      if (rxAccept && busWEop_q) begin
        rxStat_q <= statMem_q[statRd_q];
        statRd_q <= statRd_q + 1'b1;
      end
      statCnt_q <= statCnt_q + 3'(rxAcc && rxBeat.eop) - 3'(rxAccept && busWEop_q);
    end
  end

  // bus ownership, hold timer and burst beats
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busState_q  <= pbd_pkg::BUS_IDLE;
      busReqN_q   <= 1'b1;
      busFrameN_q <= 1'b1;
      busWrite_q  <= 1'b0;
      busAddr_q   <= '0;
      reqRx_q     <= 1'b0;
      latTimer_q  <= '0;
      beats_q     <= '0;
    end else if (ce) begin
      if (latTimer_q != 8'h00) latTimer_q <= latTimer_q - 8'h01; // [RULE7] [RULE8]
      if (txWe || rxAccept) beats_q <= beats_q - 8'h01;
      unique case (busState_q)
        pbd_pkg::BUS_IDLE: begin
          // rx first: a full rx fifo drops frames, tx only waits
          if (busReqN_q) begin
            if (rxWant || txWant) begin
              busReqN_q <= 1'b0;
              reqRx_q   <= rxWant;
            end
          end else if (gnt) begin
            busReqN_q   <= 1'b1;
            busFrameN_q <= 1'b0;
            latTimer_q  <= lat_q; // [RULE7]
            busWrite_q  <= reqRx_q;
            busAddr_q   <= reqRx_q ? rxAddr_q : txAddr_q;
            beats_q     <= pbd_pkg::burstLen(reqRx_q ? // [RULE18]
                             receive_config_reg_q[pbd_pkg::MAX_BURST_SIZE_LSB +: pbd_pkg::MAX_BURST_SIZE_W] :
                             transmit_config_reg_q[pbd_pkg::MAX_BURST_SIZE_LSB +: pbd_pkg::MAX_BURST_SIZE_W]);
            busState_q  <= reqRx_q ? pbd_pkg::BUS_RXWR : pbd_pkg::BUS_TXRD;
          end
        end
        pbd_pkg::BUS_TXRD, pbd_pkg::BUS_RXWR: begin
          if (busEnd) begin // [RULE9]
            busFrameN_q <= 1'b1;
            busWrite_q  <= 1'b0;
            busState_q  <= pbd_pkg::BUS_IDLE;
          end
        end
      endcase
    end
  end

  // rx beat staging toward the bus, one word in flight
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxRdPend_q  <= 1'b0;
      busWValid_q <= 1'b0;
      busWData_q  <= '0;
      busWEop_q   <= 1'b0;
    end else if (ce) begin
      rxRdPend_q <= rxRe;
      if (rxRdPend_q) begin
        busWData_q  <= pbd_pkg::endian(rxMemQ.data, bigEnd_q); // [RULE1]
        busWEop_q   <= rxMemQ.eop;
        busWValid_q <= 1'b1;
      end else if (rxAccept) begin
        busWValid_q <= 1'b0;
      end
    end
  end

  // descriptors: address and length apart from data for tx, address only for rx
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txAddr_q     <= '0;
      txRemain_q   <= '0;
      txLastFrag_q <= 1'b0;
      rxAddr_q     <= '0;
    end else if (ce) begin
      if (txWe) begin
        txAddr_q   <= txAddr_q + 32'h4;
        txRemain_q <= txRemain_q - 16'h0001;
      end else if (regWr && txRemain_q == '0) begin
        if (regAddr == pbd_pkg::OFS_TXADDR) txAddr_q <= regWData; // [RULE20]
        if (regAddr == pbd_pkg::OFS_TXLEN) begin
          txRemain_q   <= regWData[pbd_pkg::LEN_W-1:0];
          txLastFrag_q <= regWData[pbd_pkg::LASTFRAG_BIT]; // [RULE19]
        end
      end
      if (rxAccept) rxAddr_q <= rxAddr_q + 32'h4;
      else if (regWr && regAddr == pbd_pkg::OFS_RXADDR &&
               busState_q != pbd_pkg::BUS_RXWR) rxAddr_q <= regWData; // [RULE20]
    end
  end

  // interrupt status: a new event wins over the clearing read
  assign isrRd = regRd && regAddr == pbd_pkg::OFS_ISR;
  always_comb begin
    irqEv = '0;
    irqEv[pbd_pkg::IRQ_TXDONE] = txWe && txRemain_q == 16'h0001;
    irqEv[pbd_pkg::IRQ_RXDONE] = rxAccept && busWEop_q;
    irqEv[pbd_pkg::IRQ_RXOVF]  = rxValid && !rxAcc;
    isrD = (isrRd ? '0 : isr_q) | irqEv; // [RULE4]
  end

  // software registers; register data never pass the byte swap
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bigEnd_q <= 1'b0;
      imr_q    <= '0;
      transmit_config_reg_q  <= pbd_pkg::RST_TRANSMIT_CONFIG_REG;
      receive_config_reg_q  <= pbd_pkg::RST_RECEIVE_CONFIG_REG;
      lat_q    <= pbd_pkg::RST_LAT;
    end else if (ce && regWr) begin
      unique case (regAddr)
        pbd_pkg::OFS_CFG:   bigEnd_q <= regWData[pbd_pkg::CFG_BE_BIT]; // [RULE1] [RULE2]
        pbd_pkg::OFS_IMR:   imr_q    <= regWData[pbd_pkg::IRQ_W-1:0]; // [RULE5]
        pbd_pkg::OFS_TRANSMIT_CONFIG_REG: transmit_config_reg_q  <= regWData;
        pbd_pkg::OFS_RECEIVE_CONFIG_REG: receive_config_reg_q  <= regWData;
        pbd_pkg::OFS_LAT:   lat_q    <= regWData[7:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRData_q <= '0;
    end else if (ce) begin
      regRData_q <= '0;
      if (regRd) begin
        unique case (regAddr)
          pbd_pkg::OFS_CFG:    regRData_q <= {31'h0, bigEnd_q};
          pbd_pkg::OFS_ISR:    regRData_q <= 32'(isr_q);
          pbd_pkg::OFS_IMR:    regRData_q <= 32'(imr_q);
          pbd_pkg::OFS_TRANSMIT_CONFIG_REG:  regRData_q <= transmit_config_reg_q;
          pbd_pkg::OFS_RECEIVE_CONFIG_REG:  regRData_q <= receive_config_reg_q;
          pbd_pkg::OFS_LAT:    regRData_q <= {24'h0, lat_q};
          pbd_pkg::OFS_TXADDR: regRData_q <= txAddr_q;
          pbd_pkg::OFS_TXLEN:  regRData_q <= {txLastFrag_q, 15'h0, txRemain_q};
          pbd_pkg::OFS_RXADDR: regRData_q <= rxAddr_q;
          pbd_pkg::OFS_RXSTAT: regRData_q <= rxStat_q;
          pbd_pkg::OFS_STATUS: regRData_q <= {txRemain_q, 6'h0, busState_q,
                                              1'b0, statCnt_q, 1'b0, txPkts_q};
          default:             regRData_q <= '0;
        endcase
      end
    end
  end

  // interrupt flops; pin follows the next status so a clearing read drops it at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      isr_q    <= '0;
      intaOe_q <= 1'b0;
      intaOut  <= 1'b0;
    end else if (ce) begin
      isr_q    <= isrD; // [RULE4]
      intaOe_q <= |(isrD & imr_q); // [RULE3] [RULE5] [RULE6]
      intaOut  <= 1'b0; // open drain: only ever pulls low
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  sequence s_rxFetch;
    rxRe ##1 rxRdPend_q;
  endsequence
  sequence s_frameStart;
    busState_q == pbd_pkg::BUS_IDLE && !busReqN_q && gnt;
  endsequence

  property p_isrClear;
    isrRd && irqEv == '0 |=> isr_q == '0 && !intaOe_q;
  endproperty
  a_isrClear: assert property (p_isrClear) else $error("status not cleared by read"); // [RULE4]
  property p_masked;
    imr_q == '0 |=> !intaOe_q;
  endproperty
  a_masked: assert property (p_masked) else $error("masked source drove pin"); // [RULE5]
  property p_intHold;
    (isr_q & imr_q) != '0 && !isrRd |=> intaOe_q;
  endproperty
  a_intHold: assert property (p_intHold) else $error("pin released while pending"); // [RULE6]
  property p_latLoad;
    s_frameStart |=> !busFrameN_q && latTimer_q == $past(lat_q);
  endproperty
  a_latLoad: assert property (p_latLoad) else $error("hold timer not loaded"); // [RULE7]
  property p_latDown;
    !busFrameN_q && latTimer_q != 8'h00 |=> latTimer_q == $past(latTimer_q) - 8'h01;
  endproperty
  a_latDown: assert property (p_latDown) else $error("hold timer not counting"); // [RULE8]
  property p_holdBus;
    busState_q == pbd_pkg::BUS_TXRD && !txWe && latTimer_q != 8'h00 |=> !busFrameN_q;
  endproperty
  a_holdBus: assert property (p_holdBus) else $error("bus dropped before timer zero"); // [RULE9]
  property p_txReq;
    $fell(busReqN_q) && !reqRx_q |->
      txFree >= transmit_config_reg_q[pbd_pkg::FILL_LSB +: pbd_pkg::THR_W];
  endproperty
  a_txReq: assert property (p_txReq) else $error("tx request below fill threshold"); // [RULE12]
  property p_rxReq;
    $fell(busReqN_q) && reqRx_q |-> rxWant;
  endproperty
  a_rxReq: assert property (p_rxReq) else $error("rx request below drain threshold"); // [RULE16]
  property p_burstMax;
    !busFrameN_q |-> beats_q <= 8'(pbd_pkg::MAX_BURST) && txPkts_q <= pbd_pkg::PKT_LIMIT
                     && statCnt_q <= pbd_pkg::PKT_LIMIT;
  endproperty
  a_burstMax: assert property (p_burstMax) else $error("burst or packet limit passed"); // [RULE18]
  property p_rxBeat;
    s_rxFetch |=> busWValid_q && busWData_q == pbd_pkg::endian($past(rxMemQ.data), bigEnd_q);
  endproperty
  a_rxBeat: assert property (p_rxBeat) else $error("rx beat wrong or unswapped"); // [RULE1]
endmodule // pbd_bus_master
`default_nettype wire

// ===== verilog/pbd_pkg.sv
// pbd_pkg: constants, types and shared decode for the bus-master dma block
package pbd_pkg;
  // fifo geometry: 512 long words = 2 KB per direction
  localparam int FIFO_AW   = 9;
  localparam int MAX_PKTS  = 4;
  localparam int MAX_BURST = 128;
  localparam logic [2:0] PKT_LIMIT = 3'h4;

  // register byte offsets
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_ISR    = 8'h04;
  localparam logic [7:0] OFS_IMR    = 8'h08;
  localparam logic [7:0] OFS_TRANSMIT_CONFIG_REG  = 8'h0c;
  localparam logic [7:0] OFS_RECEIVE_CONFIG_REG  = 8'h10;
  localparam logic [7:0] OFS_LAT    = 8'h14;
  localparam logic [7:0] OFS_TXADDR = 8'h18;
  localparam logic [7:0] OFS_TXLEN  = 8'h1c;
  localparam logic [7:0] OFS_RXADDR = 8'h20;
  localparam logic [7:0] OFS_RXSTAT = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // field positions
  localparam int CFG_BE_BIT    = 0;
  localparam int IRQ_TXDONE    = 0;
  localparam int IRQ_RXDONE    = 1;
  localparam int IRQ_RXOVF     = 2;
  localparam int IRQ_W         = 3;
  localparam int THR_W         = 10;
  localparam int FILL_LSB      = 0;
  localparam int DRAIN_LSB     = 16;
  localparam int MAX_BURST_SIZE_LSB     = 28;
  localparam int MAX_BURST_SIZE_W       = 3;
  localparam int LEN_W         = 16;
  localparam int LASTFRAG_BIT  = 31;

  // values after reset
  localparam logic [31:0] RST_TRANSMIT_CONFIG_REG = 32'h7040_0040;
  localparam logic [31:0] RST_RECEIVE_CONFIG_REG = 32'h7000_0008;
  localparam logic [7:0]  RST_LAT   = 8'h20;

  typedef struct packed {
    logic        eop;
    logic [31:0] data;
  } pbd_beat_s;

  typedef enum logic [1:0] {BUS_IDLE, BUS_TXRD, BUS_RXWR} pbd_bus_e;

  // byte lane order of fifo data on the bus
  function automatic logic [31:0] endian(input logic [31:0] d, input logic be);
    return be ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  // burst length in long words: 1 << code, 1..128
  function automatic logic [7:0] burstLen(input logic [MAX_BURST_SIZE_W-1:0] c);
    return 8'h01 << c;
  endfunction
endpackage

// ===== verilog/pbd_fifo_mem.sv
// pbd_fifo_mem: simple dual-port fifo storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module pbd_fifo_mem #(
  parameter int AW = 9,
  parameter int W  = 33
) (
  // clock and enable
  input  wire logic          clk,
  input  wire logic          ce,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] wAddr,
  input  wire logic [W-1:0]  wData,
  // read port
  input  wire logic          re,
  input  wire logic [AW-1:0] rAddr,
  output logic      [W-1:0]  rData
);
  logic [W-1:0] mem [2**AW];

  // storage is not reset; only pointers outside give it meaning
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) mem[wAddr] <= wData;
      if (re) rData <= mem[rAddr];
    end
  end
endmodule // pbd_fifo_mem
`default_nettype wire

// ===== test/pbd_host_model.sv
// pbd_host_model: host memory and bus arbiter facing the dma bus master
`timescale 1ns/1ps
`default_nettype none
module pbd_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // bus from the device
  input  wire logic        busReqN,
  input  wire logic        busFrameN,
  input  wire logic        busWrite,
  input  wire logic [31:0] busWData,
  input  wire logic        busWValid,
  // answers to the device
  output logic             busGntN,
  output logic      [31:0] busRData,
  output logic             busRValid,
  output logic             busWAccept,
  // what reached host memory
  output logic      [31:0] lastW,
  output logic      [7:0]  wCnt
);
  logic       slowQ;
  logic [7:0] beatQ;
  // grant follows the request and is kept while a frame runs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) busGntN <= 1'b1;
    else busGntN <= busReqN && busFrameN;
  end
  // a slow host: one beat every other cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slowQ <= 1'b0;
      beatQ <= 8'h00;
    end else begin
      slowQ <= ~slowQ;
      if (busFrameN) beatQ <= 8'h00;
      else if (busRValid) beatQ <= beatQ + 8'h01;
    end
  end
  assign busRValid  = !busFrameN && !busWrite && slowQ;
  assign busWAccept = slowQ;
  // off a beat the lines carry the inverse, so stale data cannot pass
  assign busRData = busRValid ? {24'h112233, beatQ} : ~{24'h112233, beatQ};
  // record each accepted host write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lastW <= 32'h0;
      wCnt  <= 8'h00;
    end else if (busWValid && busWAccept && !busFrameN) begin
      lastW <= busWData;
      wCnt  <= wCnt + 8'h01;
    end
  end
endmodule // pbd_host_model
`default_nettype wire

// ===== test/testbench.sv
// testbench: registers, transmit, receive and interrupt checks of the dma block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] e;} pbd_row_s;
  logic               clk = 0, rstn = 0, regWr = 0, regRd = 0, ce = 1;
  logic               rxValid = 0, txReady = 0, txValid, intaOut, intaOe;
  logic [7:0]         regAddr = 8'h00, wCnt;
  logic [31:0]        regWData = 32'h0, rxStatus = 32'h0, regRData, busAddr;
  logic [31:0]        busRData, busWData, lastW, v;
  logic               busGntN, busReqN, busFrameN, busWrite;
  logic               busRValid, busWValid, busWAccept;
  pbd_pkg::pbd_beat_s rxBeat = '0, txBeat;
  pbd_pkg::pbd_beat_s got [2];
  int                 error_cnt = 0, samples_checked = 0, cyc = 0, k, n;
  pbd_row_s rows [7] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0},
    '{8'h0c, 32'h7040_0040}, '{8'h10, 32'h7000_0008}, '{8'h14, 32'h20}, '{8'h2c, 32'h0}};
  pbd_bus_master dut (.clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
    .regWData(regWData), .regWr(regWr), .regRd(regRd), .regRData(regRData),
    .busGntN(busGntN), .busReqN(busReqN), .busFrameN(busFrameN), .busWrite(busWrite),
    .busAddr(busAddr), .busRData(busRData), .busRValid(busRValid), .busWData(busWData),
    .busWValid(busWValid), .busWAccept(busWAccept), .intaOut(intaOut), .intaOe(intaOe),
    .txBeat(txBeat), .txValid(txValid), .txReady(txReady), .rxBeat(rxBeat),
    .rxValid(rxValid), .rxStatus(rxStatus));
  pbd_host_model host (.clk(clk), .rstn(rstn), .busReqN(busReqN), .busFrameN(busFrameN),
    .busWrite(busWrite), .busWData(busWData), .busWValid(busWValid), .busGntN(busGntN),
    .busRData(busRData), .busRValid(busRValid), .busWAccept(busWAccept),
    .lastW(lastW), .wCnt(wCnt));
  always #2.5 clk = ~clk;
  // compare one value and count it
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRData;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a hang is cut short well beyond the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    $display("register reset test done");
    wr(pbd_pkg::OFS_CFG, 32'h1);
    wr(pbd_pkg::OFS_RXADDR, 32'h8000_0001);
    rd(pbd_pkg::OFS_RXADDR, v);
    chk(v, 32'h8000_0001);
    // a low enable freezes the block: this write must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(pbd_pkg::OFS_LAT, 32'h0000_0055);
    ce <= 1'b1;
    rd(pbd_pkg::OFS_LAT, v);
    chk(v, 32'h0000_0020);
    // big endian transmit of one two-word last fragment
    wr(pbd_pkg::OFS_IMR, 32'h7);
    wr(pbd_pkg::OFS_TXADDR, 32'h100);
    wr(pbd_pkg::OFS_TXLEN, 32'h8000_0002);
    txReady <= 1'b1;
    k = 0;
    n = 0;
    while (n < 2 && k < 3000) begin
      @(posedge clk);
      k++;
      if (txValid === 1'b1) begin
        got[n] = txBeat;
        n++;
      end
    end
    chk(got[0].data, 32'h0033_2211);
    chk(got[1].data, 32'h0133_2211);
    chk({31'h0, got[1].eop}, 32'h1);
    k = 0;
    while (intaOe !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, intaOe}, 32'h1);
    chk({31'h0, intaOut}, 32'h0);
    chk(busAddr, 32'h0000_0100);
    rd(pbd_pkg::OFS_ISR, v);
    chk(v, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, intaOe}, 32'h0);
    rd(pbd_pkg::OFS_ISR, v);
    chk(v, 32'h0);
    $display("transmit test done");
    // masked receive of one two-word packet, little endian
    wr(pbd_pkg::OFS_CFG, 32'h0);
    wr(pbd_pkg::OFS_IMR, 32'h0);
    @(posedge clk);
    rxBeat  <= '{1'b0, 32'ha1b2_c3d4};
    rxValid <= 1'b1;
    @(posedge clk);
    rxBeat   <= '{1'b1, 32'h0000_0055};
    rxStatus <= 32'h0000_0600;
    @(posedge clk);
    rxValid <= 1'b0;
    k = 0;
    while (wCnt !== 8'h02 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk(lastW, 32'h0000_0055);
    chk({24'h0, wCnt}, 32'h0000_0002);
    chk(busAddr, 32'h8000_0001);
    repeat (4) @(posedge clk);
    chk({31'h0, intaOe}, 32'h0);
    rd(pbd_pkg::OFS_ISR, v);
    chk(v, 32'h2);
    rd(pbd_pkg::OFS_RXSTAT, v);
    chk(v, 32'h0000_0600);
    $display("receive test done");
    // reset in mid-run returns the descriptors and the bus to idle
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    rd(pbd_pkg::OFS_RXADDR, v);
    chk(v, 32'h0000_0000);
    chk({31'h0, busFrameN}, 32'h1);
    $display("reset test done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
